// file: hdl/lsiof_pkg.sv
/*
  package for the line supervision i/o filter: command codes, timing
  constants, reset values and the per-channel carrier structs.
  assumes a single 200 MHz clock and an active high asynchronous reset.
*/
package lsiof_pkg;

  localparam int NUM_CH = 4;

  // host command codes carried on the command port
  localparam logic [7:0] CMD_WR_OUT    = 8'h14; // 20: output levels
  localparam logic [7:0] CMD_RD_CHAN   = 8'h15; // 21: per-channel read
  localparam logic [7:0] CMD_WR_DIR    = 8'h16; // 22: pin directions
  localparam logic [7:0] CMD_WR_DEB    = 8'h2d; // 45: debounce time
  localparam logic [7:0] CMD_WR_FILT   = 8'h34; // 52: filter interval
  localparam logic [7:0] CMD_RD_FIRST  = 8'h10; // 16: all first inputs
  localparam logic [7:0] CMD_RD_SECOND = 8'h11; // 17: all second inputs

  // time base
  localparam int CLK_MHZ      = 200;
  localparam int TICK_US      = 1000;
  localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
  localparam int DEB_MAX_MS   = 15;
  localparam int FILT_CNT_MAX = 7;
  localparam int FILT_HI      = 5;
  localparam int FILT_LO      = 2;

  // reset values: all pins inputs, outputs low, processing off
  localparam logic [3:0] DIR_RST   = 4'h0;
  localparam logic [3:0] OUT_RST   = 4'h0;
  localparam logic [3:0] DEB_RST   = 4'h0;
  localparam logic [3:0] FILT_RST  = 4'h0;
  localparam logic [2:0] CNT_RST   = 3'h0;

  // one channel's pin pair
  typedef struct packed {
    logic second;
    logic first;
  } lsiof_pair_t;

  // per-channel state reported back to the host
  typedef struct packed {
    logic ground_key;
    logic second;
    logic first;
  } lsiof_stat_t;

endpackage : lsiof_pkg

// file: hdl/lsiof_top.sv
/*
  four-channel control/data pin block: direction, latched outputs,
  first-pin debounce, second-pin up/down filter, optional demultiplex
  and the processed read-back for the host.
  assumes host commands arrive as one-cycle strobes on CLK and the pins
  are asynchronous to CLK.
*/
// What this block does
// R1 - host selects input or output per pin of every channel, code 22
// R2 - output pins hold the level last written by code 20
// R3 - first input debounced 0 to 15 ms in 1 ms steps, code 45
// R4 - second input filtered by up/down counter, interval set by code 52
// R5 - processing only when configured; otherwise input passes straight
// R6 - host reads of first input only see the debounced value
// R7 - demux splits first input into hook bit and ground-key bit
// R8 - code 21 reads one channel, codes 16 and 17 read all four
// R9 - 1 ms tick and sample tick come from a fixed clock divider
module lsiof_top #(
  parameter int TICK_CYCLES = lsiof_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RESET,
  // host command port
  input  wire logic                      CMD_VALID,
  input  wire logic [7:0]                CMD_CODE,
  input  wire logic [1:0]                CMD_CHAN,
  input  wire logic [7:0]                CMD_DATA,
  output logic                           RD_VALID,
  output logic [7:0]                     RD_DATA,
  // demultiplex control and phase from the line circuit
  input  wire logic                      DEMUX_EN,
  input  wire logic                      DEMUX_PHASE,
  // pins, one pair per channel
  input  wire lsiof_pkg::lsiof_pair_t [3:0] PIN_IN,
  output lsiof_pkg::lsiof_pair_t [3:0]   PIN_OUT,
  output lsiof_pkg::lsiof_pair_t [3:0]   PIN_OE_N
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  lsiof_pkg::lsiof_pair_t [3:0] dir_r;
  lsiof_pkg::lsiof_pair_t [3:0] out_r;
  logic [3:0][3:0]              deb_time_r;
  logic [3:0][3:0]              filt_ivl_r;
  logic [TW-1:0]                div_r;
  logic                         tick_r;
  lsiof_pkg::lsiof_pair_t [3:0] s1_r;
  lsiof_pkg::lsiof_pair_t [3:0] s2_r;
  lsiof_pkg::lsiof_pair_t [3:0] s3_r;
  lsiof_pkg::lsiof_pair_t [3:0] clean_r;
  logic [3:0]                   phase_s1_r;
  logic [3:0]                   phase_s2_r;
  logic [3:0]                   phase_s3_r;
  logic [3:0]                   phase_cl_r;
  logic [3:0]                   hook_raw_r;
  logic [3:0]                   gkey_raw_r;
  logic [3:0][3:0]              deb_cnt_r;
  logic [3:0]                   first_q_r;
  logic [3:0][3:0]              filt_div_r;
  logic [3:0][2:0]              filt_cnt_r;
  logic [3:0]                   second_q_r;
  logic [3:0]                   gkey_q_r;
  logic                         rd_valid_r;
  logic [7:0]                   rd_data_r;

  wire cmd_dir   = CMD_VALID && (CMD_CODE == lsiof_pkg::CMD_WR_DIR);
  wire cmd_out   = CMD_VALID && (CMD_CODE == lsiof_pkg::CMD_WR_OUT);
  wire cmd_deb   = CMD_VALID && (CMD_CODE == lsiof_pkg::CMD_WR_DEB);
  wire cmd_filt  = CMD_VALID && (CMD_CODE == lsiof_pkg::CMD_WR_FILT);
  wire cmd_rd21  = CMD_VALID && (CMD_CODE == lsiof_pkg::CMD_RD_CHAN);
  wire cmd_rd16  = CMD_VALID && (CMD_CODE == lsiof_pkg::CMD_RD_FIRST);
  wire cmd_rd17  = CMD_VALID && (CMD_CODE == lsiof_pkg::CMD_RD_SECOND);
  wire tick_wrap = (div_r == TW'(TICK_CYCLES - 1));

  // three-stage synchroniser output agrees on stages two and three
  function automatic logic settle(input logic a, input logic b,
                                  input logic prev);
    settle = (a == b) ? a : prev;
  endfunction : settle

  // pins: output enable low while driving
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      assign PIN_OUT[g]  = out_r[g];                              // R2
      assign PIN_OE_N[g] = ~dir_r[g];                             // R1
    end
  endgenerate

  // configuration registers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      dir_r      <= '0;
      out_r      <= '0;
      deb_time_r <= '0;
      filt_ivl_r <= '0;
    end else begin
      if (cmd_dir)
        dir_r[CMD_CHAN] <= CMD_DATA[1:0];                         // R1
      if (cmd_out)
        out_r[CMD_CHAN] <= CMD_DATA[1:0];                         // R2
      if (cmd_deb)
        deb_time_r[CMD_CHAN] <= CMD_DATA[3:0];                    // R3
      if (cmd_filt)
        filt_ivl_r[CMD_CHAN] <= CMD_DATA[3:0];                    // R4
    end
  end

  // fixed divider for the 1 ms tick; shared with the filter sampler
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= tick_wrap ? '0 : div_r + TW'(1);                  // R9
      tick_r <= tick_wrap;                                        // R9
    end
  end

  // pin synchronisers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      s1_r       <= '0;
      s2_r       <= '0;
      s3_r       <= '0;
      clean_r    <= '0;
      phase_s1_r <= '0;
      phase_s2_r <= '0;
      phase_s3_r <= '0;
      phase_cl_r <= '0;
    end else begin
      s1_r       <= PIN_IN;
      s2_r       <= s1_r;
      s3_r       <= s2_r;
      phase_s1_r <= {4{DEMUX_PHASE}};
      phase_s2_r <= phase_s1_r;
      phase_s3_r <= phase_s2_r;
      for (int c = 0; c < 4; c++) begin
        clean_r[c].first  <= settle(s2_r[c].first, s3_r[c].first,
                                    clean_r[c].first);
        clean_r[c].second <= settle(s2_r[c].second, s3_r[c].second,
                                    clean_r[c].second);
        // phase settles in step with the pin, so no sample lands in the
        // wrong bit around a phase change
        phase_cl_r[c]     <= settle(phase_s2_r[c], phase_s3_r[c],
                                    phase_cl_r[c]);
      end
    end
  end

  // per-channel processing
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      hook_raw_r <= '0;
      gkey_raw_r <= '0;
      deb_cnt_r  <= '0;
      first_q_r  <= '0;
      filt_div_r <= '0;
      filt_cnt_r <= '0;
      second_q_r <= '0;
      gkey_q_r   <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        // demultiplex: phase high carries ground key, low carries hook
        if (!DEMUX_EN || !phase_cl_r[c])
          hook_raw_r[c] <= clean_r[c].first;                      // R7
        if (DEMUX_EN && phase_cl_r[c])
          gkey_raw_r[c] <= clean_r[c].first;                      // R7
        // first input debounce; zero time means pass through
        if (deb_time_r[c] == '0) begin
          first_q_r[c] <= hook_raw_r[c];                          // R5
          deb_cnt_r[c] <= '0;
        end else if (hook_raw_r[c] == first_q_r[c]) begin
          deb_cnt_r[c] <= '0;
        end else if (tick_r) begin
          if (deb_cnt_r[c] + 4'h1 >= deb_time_r[c]) begin
            first_q_r[c] <= hook_raw_r[c];                        // R3
            deb_cnt_r[c] <= '0;
          end else begin
            deb_cnt_r[c] <= deb_cnt_r[c] + 4'h1;                  // R3
          end
        end
        // second input (or ground key) up/down filter
        if (filt_ivl_r[c] == '0) begin
          second_q_r[c] <= DEMUX_EN ? gkey_raw_r[c]
                                    : clean_r[c].second;          // R5
        end else if (tick_r) begin
          if (filt_div_r[c] + 4'h1 >= filt_ivl_r[c]) begin
            filt_div_r[c] <= '0;
            if (DEMUX_EN ? gkey_raw_r[c] : clean_r[c].second) begin
              if (filt_cnt_r[c] != 3'(lsiof_pkg::FILT_CNT_MAX))
                filt_cnt_r[c] <= filt_cnt_r[c] + 3'h1;            // R4
            end else if (filt_cnt_r[c] != lsiof_pkg::CNT_RST) begin
              filt_cnt_r[c] <= filt_cnt_r[c] - 3'h1;              // R4
            end
            if (filt_cnt_r[c] >= 3'(lsiof_pkg::FILT_HI))
              second_q_r[c] <= 1'b1;                              // R4
            else if (filt_cnt_r[c] <= 3'(lsiof_pkg::FILT_LO))
              second_q_r[c] <= 1'b0;                              // R4
          end else begin
            filt_div_r[c] <= filt_div_r[c] + 4'h1;
          end
        end
        // ground key reads as zero unless demultiplex is on
        gkey_q_r[c] <= DEMUX_EN && second_q_r[c];                 // R7
      end
    end
  end

  // read-back: only processed values reach the host
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rd_valid_r <= 1'b0;
      rd_data_r  <= '0;
    end else begin
      rd_valid_r <= cmd_rd21 || cmd_rd16 || cmd_rd17;
      if (cmd_rd21)
        rd_data_r <= {5'h00, gkey_q_r[CMD_CHAN], second_q_r[CMD_CHAN],
                      first_q_r[CMD_CHAN]};                       // R8 R6
      else if (cmd_rd16)
        rd_data_r <= {4'h0, first_q_r};                           // R8 R6
      else if (cmd_rd17)
        rd_data_r <= {4'h0, second_q_r};                          // R8
    end
  end

  assign RD_VALID = rd_valid_r;
  assign RD_DATA  = rd_data_r;

endmodule : lsiof_top

// file: verification/lsiof_line_model.sv
/*
  line circuit model: drives every pin the device leaves as an input.
  assumes pin pairs packed {second,first} per channel.
*/
module lsiof_line_model (
  // levels the line circuit wants
  input  wire logic [7:0] lvl,
  // device side of the pins
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // a pin the device drives shows the device level, never ours
  assign pin_in = (pin_out & ~pin_oe_n) | (lvl & pin_oe_n);
endmodule : lsiof_line_model

// file: verification/lsiof_top_checker.sv
/*
  checker for lsiof_top: command effects on the pins and read timing.
  assumes it is bound to lsiof_top and sees only its ports.
*/
module lsiof_top_checker #(
  parameter int TICK_CYCLES = 20
) (
  // clock and reset
  input wire logic                         CLK,
  input wire logic                         RESET,
  // command port and answer
  input wire logic                         CMD_VALID,
  input wire logic [7:0]                   CMD_CODE,
  input wire logic [1:0]                   CMD_CHAN,
  input wire logic [7:0]                   CMD_DATA,
  input wire logic                         RD_VALID,
  input wire logic [7:0]                   RD_DATA,
  // pins
  input wire lsiof_pkg::lsiof_pair_t [3:0] PIN_OUT,
  input wire lsiof_pkg::lsiof_pair_t [3:0] PIN_OE_N
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  wire wr_o = CMD_VALID && CMD_CODE == lsiof_pkg::CMD_WR_OUT;
  wire wr_d = CMD_VALID && CMD_CODE == lsiof_pkg::CMD_WR_DIR;
  wire rd   = CMD_VALID && (CMD_CODE == lsiof_pkg::CMD_RD_FIRST ||
              CMD_CODE == lsiof_pkg::CMD_RD_SECOND ||
              CMD_CODE == lsiof_pkg::CMD_RD_CHAN);
  wire rd21 = CMD_VALID && CMD_CODE == lsiof_pkg::CMD_RD_CHAN;
  // a lone read must give exactly one answer pulse
  sequence s_lone_rd; rd ##1 !rd; endsequence
  sequence s_pulse; RD_VALID ##1 !RD_VALID; endsequence
  property p_dir;
    wr_d |=> PIN_OE_N[$past(CMD_CHAN)] == ~$past(CMD_DATA[1:0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not set");
  property p_dir_hold; !wr_d |=> $stable(PIN_OE_N); endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("dir moved");
  property p_out;
    wr_o |=> PIN_OUT[$past(CMD_CHAN)] == $past(CMD_DATA[1:0]);
  endproperty
  a_out: assert property (p_out) else $error("output not latched");
  property p_out_hold; !wr_o |=> $stable(PIN_OUT); endproperty
  a_out_hold: assert property (p_out_hold) else $error("out moved");
  property p_rd; s_lone_rd |-> s_pulse; endproperty
  a_rd: assert property (p_rd) else $error("read answer pulse");
  property p_rd_cause; RD_VALID |-> $past(rd); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("stray answer");
  property p_rd_hold; !RD_VALID |-> $stable(RD_DATA); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("data moved");
  property p_rd_top; RD_VALID |-> RD_DATA[7:4] == 4'h0; endproperty
  a_rd_top: assert property (p_rd_top) else $error("upper bits set");
  property p_rd21_top; rd21 |=> RD_DATA[7:3] == 5'h00; endproperty
  a_rd21_top: assert property (p_rd21_top) else $error("chan read");
endmodule : lsiof_top_checker

bind lsiof_top lsiof_top_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .CLK(CLK), .RESET(RESET), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE),
  .CMD_CHAN(CMD_CHAN), .CMD_DATA(CMD_DATA), .RD_VALID(RD_VALID),
  .RD_DATA(RD_DATA), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N));

// file: verification/lsiof_top_tb.sv
/*
  self-checking bench for lsiof_top with the line circuit model.
  assumes a 20-cycle tick, so one design millisecond is 100 ns.
*/
module lsiof_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                         CLK, RESET, CMD_VALID, RD_VALID;
  logic                         DEMUX_EN, DEMUX_PHASE;
  logic [7:0]                   CMD_CODE, CMD_DATA, RD_DATA, lvl, rdata;
  logic [1:0]                   CMD_CHAN;
  lsiof_pkg::lsiof_pair_t [3:0] PIN_IN, PIN_OUT, PIN_OE_N;
  int                           fails, total_checks, cyc;
  lsiof_top #(.TICK_CYCLES(20)) dut (.CLK(CLK), .RESET(RESET),
    .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_CHAN(CMD_CHAN),
    .CMD_DATA(CMD_DATA), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
    .DEMUX_EN(DEMUX_EN), .DEMUX_PHASE(DEMUX_PHASE), .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N));
  lsiof_line_model line (.lvl(lvl), .pin_out(PIN_OUT),
    .pin_oe_n(PIN_OE_N), .pin_in(PIN_IN));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] c, input logic [1:0] ch,
                     input logic [7:0] d);
    @(posedge CLK);
    #1;
    CMD_VALID = 1'b1;
    CMD_CODE = c;
    CMD_CHAN = ch;
    CMD_DATA = d;
    @(posedge CLK);
    #1;
    CMD_VALID = 1'b0;
  endtask : cmd
  // answer is due one cycle after the strobe edge, no sooner or later
  task automatic rd(input logic [7:0] c, input logic [1:0] ch);
    cmd(c, ch, 8'h00);
    chk({7'h0, RD_VALID}, 8'h01);
    rdata = RD_DATA;
  endtask : rd
  task automatic t_pass;
    repeat (10) @(posedge CLK);
    rd(lsiof_pkg::CMD_RD_FIRST, 2'h0);
    chk(rdata, 8'h06);
    rd(lsiof_pkg::CMD_RD_SECOND, 2'h0);
    chk(rdata, 8'h0a);
    rd(lsiof_pkg::CMD_RD_CHAN, 2'h1);
    chk(rdata, 8'h03);
    rd(lsiof_pkg::CMD_RD_CHAN, 2'h2);
    chk(rdata, 8'h01);
  endtask : t_pass
  task automatic t_deb;
    cmd(lsiof_pkg::CMD_WR_DEB, 2'h0, 8'h03);
    lvl[0] = 1'b1;
    repeat (30) @(posedge CLK);
    rd(lsiof_pkg::CMD_RD_FIRST, 2'h0);
    chk(rdata, 8'h06);
    repeat (70) @(posedge CLK);
    rd(lsiof_pkg::CMD_RD_FIRST, 2'h0);
    chk(rdata, 8'h07);
  endtask : t_deb
  task automatic t_filt;
    cmd(lsiof_pkg::CMD_WR_FILT, 2'h0, 8'h01);
    lvl[1] = 1'b1;
    repeat (40) @(posedge CLK);
    rd(lsiof_pkg::CMD_RD_SECOND, 2'h0);
    chk(rdata, 8'h0a);
    repeat (160) @(posedge CLK);
    rd(lsiof_pkg::CMD_RD_SECOND, 2'h0);
    chk(rdata, 8'h0b);
  endtask : t_filt
  // channel 2 first pin: ground key 1 in high phase, hook 0 in low phase
  task automatic t_demux;
    @(posedge CLK);
    #1;
    DEMUX_EN = 1'b1;
    DEMUX_PHASE = 1'b1;
    repeat (10) @(posedge CLK);
    #1;
    DEMUX_PHASE = 1'b0;
    lvl[4] = 1'b0;
    repeat (10) @(posedge CLK);
    rd(lsiof_pkg::CMD_RD_CHAN, 2'h2);
    chk(rdata, 8'h06);
    rd(lsiof_pkg::CMD_RD_SECOND, 2'h0);
    chk(rdata, 8'h07);
    rd(lsiof_pkg::CMD_RD_FIRST, 2'h0);
    chk(rdata, 8'h03);
    DEMUX_EN = 1'b0;
  endtask : t_demux
  task automatic t_pins;
    logic [7:0] eo;
    eo = 8'h00;
    for (int ch = 0; ch < 4; ch++) begin
      cmd(lsiof_pkg::CMD_WR_DIR, ch[1:0], 8'h03);
      chk(PIN_OE_N, 8'hff << (2 * ch + 2));
      cmd(lsiof_pkg::CMD_WR_OUT, ch[1:0], {6'h0, ch[1:0]});
      eo = eo | (8'(ch) << (2 * ch));
      chk(PIN_OUT, eo);
    end
    cmd(8'hff, 2'h3, 8'h00);
    chk(PIN_OUT, eo);
    cmd(lsiof_pkg::CMD_WR_DIR, 2'h0, 8'h01);
    chk(PIN_OE_N, 8'h02);
  endtask : t_pins
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  // a hang is cut short well past the expected 380 cycles
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    RESET = 1'b1;
    CMD_VALID = 1'b0;
    CMD_CODE = 8'h00;
    CMD_CHAN = 2'h0;
    CMD_DATA = 8'h00;
    DEMUX_EN = 1'b0;
    DEMUX_PHASE = 1'b0;
    lvl = 8'h9c;
    fails = 0;
    total_checks = 0;
    cyc = 0;
    repeat (2) @(posedge CLK);
    #1;
    RESET = 1'b0;
    chk(PIN_OE_N, 8'hff);
    t_pass();
    t_deb();
    t_filt();
    t_demux();
    t_pins();
    summarize();
  end
endmodule : lsiof_top_tb
